/* File: src/ctis_top.sv */
`timescale 1ns/1ps
module ctis_top (
  input wire logic mclk_in,
  input wire logic rst_n_in,
  input wire ctis_pkg::ctis_bus_s bus_in,
  input wire logic interrupt_acknowledge_n_in,
  input wire logic [3:0] input_pins_in,
  input wire logic tx_clock_1x_in,
  input wire ctis_pkg::ctis_src_s src_in,
  output logic [7:0] rdata_out,
  output logic interrupt_request_n_out,
  output logic timer_output_pin_out,
  output logic timer_output_pin_oe_out
);
  import ctis_pkg::*;

  // ****************************************************************
  // Pin synchronisers and edge detection
  // ****************************************************************
  logic [3:0] pin_meta_q;
  logic [3:0] pin_sync_q;
  logic [3:0] pin_prev_q;
  logic [3:0] pin_change;
  logic [1:0] tx_clk_sync_q;
  logic tx_clk_prev_q;

  // Two flops per asynchronous input, then a history flop
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pin_meta_q <= 4'h0;
      pin_sync_q <= 4'h0;
      pin_prev_q <= 4'h0;
      tx_clk_sync_q <= 2'h0;
      tx_clk_prev_q <= 1'b0;
    end else begin
      pin_meta_q <= input_pins_in;
      pin_sync_q <= pin_meta_q;
      pin_prev_q <= pin_sync_q;
      tx_clk_sync_q <= {tx_clk_sync_q[0], tx_clock_1x_in};
      tx_clk_prev_q <= tx_clk_sync_q[1];
    end
  end

  assign pin_change = pin_sync_q ^ pin_prev_q;

  // ****************************************************************
  // Bus decode
  // ****************************************************************
  logic rd_change;
  logic rd_start;
  logic rd_stop;
  logic wr_aux;
  logic wr_mask;
  logic wr_upper;
  logic wr_lower;
  logic wr_vector;
  logic wr_outsel;

  assign rd_change = bus_in.rd && bus_in.addr == CTIS_OFS_INPUT_CHANGE;
  assign rd_start = bus_in.rd && bus_in.addr == CTIS_OFS_START;
  assign rd_stop = bus_in.rd && bus_in.addr == CTIS_OFS_STOP;
  assign wr_aux = bus_in.wr && bus_in.addr == CTIS_OFS_AUX_CTRL;
  assign wr_mask = bus_in.wr && bus_in.addr == CTIS_OFS_STATUS_MASK;
  assign wr_upper = bus_in.wr && bus_in.addr == CTIS_OFS_COUNT_UPPER;
  assign wr_lower = bus_in.wr && bus_in.addr == CTIS_OFS_COUNT_LOWER;
  assign wr_vector = bus_in.wr && bus_in.addr == CTIS_OFS_VECTOR;
  assign wr_outsel = bus_in.wr && bus_in.addr == CTIS_OFS_OUT_SELECT;

  // ****************************************************************
  // Control registers
  // ****************************************************************
  logic [7:0] auxiliary_control_q;
  logic [7:0] interrupt_mask_q;
  logic [15:0] preset_q;
  logic [7:0] vector_or_scratch_q;
  logic [1:0] op3_select_q;
  ctis_mode_e mode;

  // Software-written configuration
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      auxiliary_control_q <= CTIS_AUX_RESET;
      interrupt_mask_q <= CTIS_MASK_RESET;
      preset_q <= CTIS_PRESET_RESET;
      vector_or_scratch_q <= CTIS_VECTOR_RESET;
      op3_select_q <= 2'h0;
    end else begin
      if (wr_aux) begin
        auxiliary_control_q <= bus_in.wdata;
      end
      if (wr_mask) begin
        interrupt_mask_q <= bus_in.wdata & CTIS_STATUS_USED;
      end
      if (wr_upper) begin
        preset_q[15:8] <= bus_in.wdata;
      end
      if (wr_lower) begin
        preset_q[7:0] <= bus_in.wdata;
      end
      if (wr_vector) begin
        vector_or_scratch_q <= bus_in.wdata;
      end
      if (wr_outsel) begin
        op3_select_q <= bus_in.wdata[3:2];
      end
    end
  end

  assign mode = ctis_mode_e'(auxiliary_control_q[6:4]);

  // ****************************************************************
  // Counter/timer clock source
  // ****************************************************************
  logic src_edge;
  logic timer_mode;
  logic div16_sel;
  logic [3:0] prescale_q;
  logic tick;

  // Rising edges of the chosen source, optionally divided by 16
  always_comb begin
    src_edge = 1'b0;
    div16_sel = 1'b0;
    case (mode)
      CTIS_CNT_EXT: src_edge = pin_sync_q[2] && !pin_prev_q[2];
      CTIS_CNT_TX1X: src_edge = tx_clk_sync_q[1] && !tx_clk_prev_q;
      CTIS_CNT_XTAL16: begin
        src_edge = 1'b1;
        div16_sel = 1'b1;
      end
      CTIS_TMR_EXT: src_edge = pin_sync_q[2] && !pin_prev_q[2];
      CTIS_TMR_EXT16: begin
        src_edge = pin_sync_q[2] && !pin_prev_q[2];
        div16_sel = 1'b1;
      end
      CTIS_TMR_XTAL: src_edge = 1'b1;
      CTIS_TMR_XTAL16: begin
        src_edge = 1'b1;
        div16_sel = 1'b1;
      end
      default: src_edge = 1'b0;
    endcase
  end

  assign timer_mode = auxiliary_control_q[6];

  // Prescaler restarts with each start so cycles align
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      prescale_q <= 4'h0;
    end else if (rd_start) begin
      prescale_q <= 4'h0;
    end else if (src_edge) begin
      prescale_q <= prescale_q + 4'h1;
    end
  end

  assign tick = src_edge && (!div16_sel || prescale_q == CTIS_PRESCALE_LAST);

  // ****************************************************************
  // Counter/timer core
  // ****************************************************************
  typedef enum logic [1:0] {
    CTIS_IDLE = 2'b01,
    CTIS_RUN = 2'b10
  } ctis_state_e;

  ctis_state_e state_q;
  logic [15:0] count_q;
  logic wave_q;
  logic ready_set;
  logic terminal;

  assign terminal = count_q == 16'h0001;

  // Start reloads; timer reloads each half-period; counter wraps freely
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_q <= CTIS_IDLE;
      count_q <= 16'h0000;
      wave_q <= 1'b1;
      ready_set <= 1'b0;
    end else begin
      ready_set <= 1'b0;
      case (state_q)
        CTIS_IDLE: begin
          if (rd_start) begin
            state_q <= CTIS_RUN;
            count_q <= preset_q;
            wave_q <= 1'b1;
          end
        end
        CTIS_RUN: begin
          if (rd_start) begin
            count_q <= preset_q;
            wave_q <= 1'b1;
          end else if (timer_mode) begin
            if (tick && terminal) begin
              count_q <= preset_q;
              wave_q <= !wave_q;
              ready_set <= !wave_q;
            end else if (tick) begin
              count_q <= count_q - 16'h0001;
            end
          end else begin
            if (rd_stop) begin
              state_q <= CTIS_IDLE;
              wave_q <= 1'b1;
            end else if (tick) begin
              count_q <= count_q - 16'h0001;
              if (terminal) begin
                wave_q <= 1'b0;
                ready_set <= 1'b1;
              end
            end
          end
        end
        default: state_q <= CTIS_IDLE;
      endcase
    end
  end

  // ****************************************************************
  // Input change and interrupt status
  // ****************************************************************
  logic [3:0] change_q;
  logic [7:0] interrupt_status_q;
  logic input_event;

  assign input_event = |(pin_change & auxiliary_control_q[3:0]);

  // Change flags: a change in the read cycle survives
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      change_q <= 4'h0;
    end else begin
      change_q <= (rd_change ? 4'h0 : change_q) | pin_change;
    end
  end

  // Status bits 7, 3 and 2 are sticky, set wins over clear; RX and TX bits follow their levels
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      interrupt_status_q <= CTIS_STATUS_RESET;
    end else begin
      interrupt_status_q[CTIS_BIT_INPUT_CHANGE] <=
        (interrupt_status_q[CTIS_BIT_INPUT_CHANGE] && !rd_change) || input_event;
      interrupt_status_q[6:4] <= 3'h0;
      interrupt_status_q[CTIS_BIT_COUNTER_READY] <=
        (interrupt_status_q[CTIS_BIT_COUNTER_READY] && !rd_stop) || ready_set;
      interrupt_status_q[CTIS_BIT_BREAK] <=
        (interrupt_status_q[CTIS_BIT_BREAK] && !src_in.break_reset_cmd) || src_in.break_event;
      interrupt_status_q[CTIS_BIT_RX] <= src_in.rx_level;
      interrupt_status_q[CTIS_BIT_TX] <= src_in.tx_level;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  logic timer_pin_sel;
  assign timer_pin_sel = op3_select_q == CTIS_OP3_SEL_TIMER;

  // Interrupt line and open-drain timer pin
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      interrupt_request_n_out <= 1'b1;
      timer_output_pin_out <= 1'b0;
      timer_output_pin_oe_out <= 1'b0;
    end else begin
      interrupt_request_n_out <= !(|(interrupt_status_q & interrupt_mask_q));
      timer_output_pin_out <= 1'b0;
      timer_output_pin_oe_out <= timer_pin_sel && !wave_q;
    end
  end

  // Read data: acknowledge takes priority and returns the vector
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rdata_out <= 8'h00;
    end else if (!interrupt_acknowledge_n_in) begin
      rdata_out <= vector_or_scratch_q;
    end else if (bus_in.rd) begin
      case (bus_in.addr)
        CTIS_OFS_INPUT_CHANGE: rdata_out <= {change_q, pin_sync_q};
        CTIS_OFS_STATUS_MASK: rdata_out <= interrupt_status_q;
        CTIS_OFS_COUNT_UPPER: rdata_out <= count_q[15:8];
        CTIS_OFS_COUNT_LOWER: rdata_out <= count_q[7:0];
        CTIS_OFS_VECTOR: rdata_out <= vector_or_scratch_q;
        default: rdata_out <= 8'h00;
      endcase
    end else begin
      rdata_out <= 8'h00;
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  a_irq_follows_mask: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    ##1 (interrupt_request_n_out == !(|($past(interrupt_status_q) & $past(interrupt_mask_q)))))
    else $error("interrupt line disagrees with status and mask");
  a_change_clears_status: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    (rd_change && !input_event) |=> !interrupt_status_q[CTIS_BIT_INPUT_CHANGE])
    else $error("input change status not cleared by read");
  a_change_latches: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    (pin_change != 4'h0) |=> ((change_q & $past(pin_change)) == $past(pin_change)))
    else $error("pin change not latched");
  a_unused_zero: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    interrupt_status_q[6:4] == 3'h0)
    else $error("unused status bits set");
  a_stop_clears_ready: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    (rd_stop && !ready_set) |=> !interrupt_status_q[CTIS_BIT_COUNTER_READY])
    else $error("stop did not clear counter ready");
  a_start_reloads: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    rd_start |=> (count_q == $past(preset_q) && state_q == CTIS_RUN))
    else $error("start did not reload preset");
  a_break_sticky: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    (interrupt_status_q[CTIS_BIT_BREAK] && !src_in.break_reset_cmd) |=> interrupt_status_q[CTIS_BIT_BREAK])
    else $error("break change lost without command");
  a_vector_on_ack: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    !interrupt_acknowledge_n_in |=> rdata_out == $past(vector_or_scratch_q))
    else $error("vector not returned on acknowledge");
  a_counter_stop_high: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    (rd_stop && !timer_mode && state_q == CTIS_RUN) |=> ##1 !timer_output_pin_oe_out)
    else $error("timer pin not released after stop");
  a_live_levels: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    (rd_change && interrupt_acknowledge_n_in) |=> rdata_out[3:0] == $past(pin_sync_q))
    else $error("input change read lost live pin levels");
  a_summary_needs_enable: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    (!input_event && !interrupt_status_q[CTIS_BIT_INPUT_CHANGE]) |=> !interrupt_status_q[CTIS_BIT_INPUT_CHANGE])
    else $error("input change status set without enabled change");
  a_idle_no_ready: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    (state_q == CTIS_IDLE) |=> !ready_set)
    else $error("counter ready raised while idle");
  a_timer_reload: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    (timer_mode && state_q == CTIS_RUN && !rd_start && tick && terminal) |=>
      (count_q == $past(preset_q) && wave_q != $past(wave_q)))
    else $error("timer half-period did not reload and toggle");
  a_counter_terminal: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    (!timer_mode && state_q == CTIS_RUN && !rd_start && !rd_stop && tick && terminal) |=>
      (count_q == 16'h0000 && !wave_q && ready_set))
    else $error("counter terminal count not flagged");
  a_counter_holds: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    (!timer_mode && !rd_start && !tick) |=> count_q == $past(count_q))
    else $error("counter value moved without a tick or start");

endmodule : ctis_top

/* File: common/ctis_pkg.sv */
package ctis_pkg;

  // ****************************************************************
  // Register offsets (A3..A0)
  // ****************************************************************
  localparam logic [3:0] CTIS_OFS_AUX_CTRL = 4'h4;
  localparam logic [3:0] CTIS_OFS_INPUT_CHANGE = 4'h4;
  localparam logic [3:0] CTIS_OFS_STATUS_MASK = 4'h5;
  localparam logic [3:0] CTIS_OFS_COUNT_UPPER = 4'h6;
  localparam logic [3:0] CTIS_OFS_COUNT_LOWER = 4'h7;
  localparam logic [3:0] CTIS_OFS_VECTOR = 4'hc;
  localparam logic [3:0] CTIS_OFS_OUT_SELECT = 4'hd;
  localparam logic [3:0] CTIS_OFS_START = 4'he;
  localparam logic [3:0] CTIS_OFS_STOP = 4'hf;

  // ****************************************************************
  // Reset values and field positions
  // ****************************************************************
  localparam logic [7:0] CTIS_STATUS_RESET = 8'h00;
  localparam logic [7:0] CTIS_VECTOR_RESET = 8'h0f;
  localparam logic [7:0] CTIS_AUX_RESET = 8'h00;
  localparam logic [7:0] CTIS_MASK_RESET = 8'h00;
  localparam logic [15:0] CTIS_PRESET_RESET = 16'h0002;
  localparam logic [7:0] CTIS_STATUS_USED = 8'h8f;
  localparam int CTIS_BIT_INPUT_CHANGE = 7;
  localparam int CTIS_BIT_COUNTER_READY = 3;
  localparam int CTIS_BIT_BREAK = 2;
  localparam int CTIS_BIT_RX = 1;
  localparam int CTIS_BIT_TX = 0;
  localparam logic [1:0] CTIS_OP3_SEL_TIMER = 2'h1;
  localparam logic [3:0] CTIS_PRESCALE_LAST = 4'hf;

  // ****************************************************************
  // Mode and clock source field
  // ****************************************************************
  typedef enum logic [2:0] {
    CTIS_CNT_EXT = 3'h0,
    CTIS_CNT_TX1X = 3'h1,
    CTIS_RESERVED = 3'h2,
    CTIS_CNT_XTAL16 = 3'h3,
    CTIS_TMR_EXT = 3'h4,
    CTIS_TMR_EXT16 = 3'h5,
    CTIS_TMR_XTAL = 3'h6,
    CTIS_TMR_XTAL16 = 3'h7
  } ctis_mode_e;

  // Host bus request
  typedef struct packed {
    logic rd;
    logic wr;
    logic [3:0] addr;
    logic [7:0] wdata;
  } ctis_bus_s;

  // Status sources from receiver and transmitter
  typedef struct packed {
    logic break_event;
    logic break_reset_cmd;
    logic rx_level;
    logic tx_level;
  } ctis_src_s;

endpackage : ctis_pkg

/* File: test/ctis_host_model.sv */
`timescale 1ns/1ps
module ctis_host_model (
  input wire logic mclk_in,
  input wire logic [7:0] rdata_in,
  output ctis_pkg::ctis_bus_s bus_out
);
  import ctis_pkg::*;
  // ****************************************************************
  // Host register bus cycles
  // ****************************************************************
  // Bus idle at time zero
  initial begin
    bus_out = '0;
  end
  // One write; data lines show the inverse once released
  task automatic wr(input logic [3:0] addr, input logic [7:0] data);
    @(posedge mclk_in);
    bus_out <= '{rd: 1'b0, wr: 1'b1, addr: addr, wdata: data};
    @(posedge mclk_in);
    bus_out.wr <= 1'b0;
    bus_out.wdata <= ~data;
  endtask : wr
  // One read; data taken just after the edge that registers it
  task automatic rd(input logic [3:0] addr, output logic [7:0] data);
    @(posedge mclk_in);
    bus_out.rd <= 1'b1;
    bus_out.addr <= addr;
    @(posedge mclk_in);
    bus_out.rd <= 1'b0;
    #1;
    data = rdata_in;
  endtask : rd
  // Mask write keeps reserved bits at zero
  task automatic wr_mask(input logic [7:0] m);
    wr(CTIS_OFS_STATUS_MASK, m & CTIS_STATUS_USED);
  endtask : wr_mask
  // Preset write never goes below two
  task automatic wr_preset(input logic [15:0] v);
    if (v < 16'h0002) begin
      v = 16'h0002;
    end
    wr(CTIS_OFS_COUNT_UPPER, v[15:8]);
    wr(CTIS_OFS_COUNT_LOWER, v[7:0]);
  endtask : wr_preset
endmodule : ctis_host_model

/* File: test/ctis_top_test.sv */
`timescale 1ns/1ps
module ctis_top_test;
  import ctis_pkg::*;
  logic mclk_in = 1'b0;
  logic rst_n_in = 1'b0;
  ctis_bus_s bus;
  logic ack_n = 1'b1;
  logic [3:0] pins = 4'h0;
  logic ext_clk = 1'b0;
  logic ext_run = 1'b0;
  ctis_src_s src = '0;
  logic [7:0] rdata;
  logic irq_n;
  logic pin_q;
  logic pin_oe;
  logic [7:0] d;
  int p;
  int mismatches = 0;
  int total_checks = 0;

  // Clock at 50 ns period
  always #25 mclk_in = ~mclk_in;

  // External clock source: toggles every cycle while enabled
  always @(posedge mclk_in) begin
    if (ext_run) begin
      ext_clk <= ~ext_clk;
    end
  end

  // ****************************************************************
  // Device and host
  // ****************************************************************
  // Pin 2 and the transmitter clock share the external clock source
  ctis_top DUT (.mclk_in(mclk_in), .rst_n_in(rst_n_in), .bus_in(bus), .interrupt_acknowledge_n_in(ack_n),
    .input_pins_in(pins ^ {1'b0, ext_clk, 2'h0}), .tx_clock_1x_in(ext_clk), .src_in(src), .rdata_out(rdata),
    .interrupt_request_n_out(irq_n), .timer_output_pin_out(pin_q), .timer_output_pin_oe_out(pin_oe));
  ctis_host_model host (.mclk_in(mclk_in), .rdata_in(rdata), .bus_out(bus));

  // ****************************************************************
  // Compare and helper tasks
  // ****************************************************************
  task automatic check8(input logic [7:0] got, input logic [7:0] exp, input string what);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : check8
  task automatic check1(input logic got, input logic exp, input string what);
    check8({7'h00, got}, {7'h00, exp}, what);
  endtask : check1
  task automatic wait_cycles(input int n);
    repeat (n) @(posedge mclk_in);
    #1;
  endtask : wait_cycles
  // Cycles between two rising edges of the pin enable, 0 if none
  task automatic measure_period(output int per);
    int first;
    logic prev;
    first = -1;
    per = 0;
    prev = pin_oe;
    for (int i = 0; i < 200 && per == 0; i++) begin
      wait_cycles(1);
      if (pin_oe === 1'b1 && prev === 1'b0) begin
        if (first < 0) first = i;
        else per = i - first;
      end
      prev = pin_oe;
    end
  endtask : measure_period
  task automatic stop_test;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : stop_test

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic test_reset;
    host.rd(CTIS_OFS_STATUS_MASK, d);
    check8(d, 8'h00, "status after reset");
    host.rd(CTIS_OFS_VECTOR, d);
    check8(d, 8'h0f, "vector after reset");
    check1(irq_n, 1'b1, "irq idle");
    check1(pin_oe, 1'b0, "timer pin released after reset");
  endtask : test_reset
  task automatic test_vector;
    host.wr(CTIS_OFS_VECTOR, 8'h5a);
    host.rd(CTIS_OFS_VECTOR, d);
    check8(d, 8'h5a, "scratch storage");
    @(posedge mclk_in);
    ack_n <= 1'b0;
    wait_cycles(1);
    check8(rdata, 8'h5a, "vector on acknowledge");
    @(posedge mclk_in);
    ack_n <= 1'b1;
  endtask : test_vector
  task automatic test_input_change;
    host.wr(CTIS_OFS_AUX_CTRL, 8'h01);
    host.wr_mask(8'h80);
    @(posedge mclk_in);
    pins <= 4'h1;
    wait_cycles(6);
    check1(irq_n, 1'b0, "irq on enabled change");
    host.rd(CTIS_OFS_STATUS_MASK, d);
    check8(d, 8'h80, "change summary set");
    host.rd(CTIS_OFS_INPUT_CHANGE, d);
    check8(d, 8'h11, "change flags and levels");
    host.rd(CTIS_OFS_STATUS_MASK, d);
    check8(d, 8'h00, "summary cleared by read");
    check1(irq_n, 1'b1, "irq released");
    @(posedge mclk_in);
    pins <= 4'hb;
    wait_cycles(6);
    host.rd(CTIS_OFS_STATUS_MASK, d);
    check8(d, 8'h00, "disabled pin ignored");
    host.rd(CTIS_OFS_INPUT_CHANGE, d);
    check8(d, 8'hab, "live levels");
  endtask : test_input_change
  task automatic test_sources;
    host.wr_mask(8'h00);
    @(posedge mclk_in);
    src.break_event <= 1'b1;
    @(posedge mclk_in);
    src.break_event <= 1'b0;
    wait_cycles(3);
    host.rd(CTIS_OFS_STATUS_MASK, d);
    check8(d, 8'h04, "break change seen unmasked");
    check1(irq_n, 1'b1, "masked status quiet");
    host.wr_mask(8'h04);
    wait_cycles(2);
    check1(irq_n, 1'b0, "unmasked break irq");
    host.rd(CTIS_OFS_STATUS_MASK, d);
    check8(d, 8'h04, "break held");
    @(posedge mclk_in);
    src.break_reset_cmd <= 1'b1;
    @(posedge mclk_in);
    src.break_reset_cmd <= 1'b0;
    wait_cycles(3);
    host.rd(CTIS_OFS_STATUS_MASK, d);
    check8(d, 8'h00, "break cleared by command");
    @(posedge mclk_in);
    src.rx_level <= 1'b1;
    src.tx_level <= 1'b1;
    wait_cycles(3);
    host.rd(CTIS_OFS_STATUS_MASK, d);
    check8(d, 8'h03, "rx and tx levels");
    @(posedge mclk_in);
    src.rx_level <= 1'b0;
    src.tx_level <= 1'b0;
  endtask : test_sources
  task automatic test_timer;
    host.wr_mask(8'h00);
    host.wr_preset(16'h0004);
    host.wr(CTIS_OFS_AUX_CTRL, 8'h60);
    host.wr(CTIS_OFS_OUT_SELECT, 8'h04);
    host.rd(CTIS_OFS_START, d);
    measure_period(p);
    check8(p[7:0], 8'h08, "square wave period");
    check1(pin_q, 1'b0, "open-drain data low");
    host.rd(CTIS_OFS_STATUS_MASK, d);
    check8(d, 8'h08, "ready once per cycle");
    // Keep the stop clear of a fresh ready set, which would win
    wait_cycles(2);
    host.rd(CTIS_OFS_STOP, d);
    host.rd(CTIS_OFS_STATUS_MASK, d);
    check8(d, 8'h00, "stop clears ready");
    measure_period(p);
    check8(p[7:0], 8'h08, "timer runs after stop");
    host.wr_preset(16'h0006);
    measure_period(p);
    measure_period(p);
    check8(p[7:0], 8'h0c, "new preset next half");
  endtask : test_timer
  task automatic test_counter;
    host.wr_preset(16'h0002);
    host.wr(CTIS_OFS_AUX_CTRL, 8'h30);
    // Timer left counter ready set; stop clears it before the count
    host.rd(CTIS_OFS_STOP, d);
    host.rd(CTIS_OFS_START, d);
    wait_cycles(8);
    check1(pin_oe, 1'b0, "output high before terminal");
    host.rd(CTIS_OFS_STATUS_MASK, d);
    check8(d, 8'h00, "not ready before terminal");
    wait_cycles(50);
    check1(pin_oe, 1'b1, "output low at terminal");
    host.rd(CTIS_OFS_STATUS_MASK, d);
    check8(d, 8'h08, "ready at terminal");
    host.rd(CTIS_OFS_STOP, d);
    wait_cycles(1);
    check1(pin_oe, 1'b0, "stop returns output high");
    host.rd(CTIS_OFS_STATUS_MASK, d);
    check8(d, 8'h00, "stop clears ready");
  endtask : test_counter
  // Counter on the transmitter clock, timer on pin 2 and on the divided crystal
  task automatic test_clock_sources;
    host.wr(CTIS_OFS_AUX_CTRL, 8'h10);
    host.rd(CTIS_OFS_START, d);
    wait_cycles(4);
    check1(pin_oe, 1'b0, "counter holds without tx clock");
    @(posedge mclk_in);
    ext_run <= 1'b1;
    wait_cycles(10);
    check1(pin_oe, 1'b1, "counter reaches terminal on tx clock");
    host.rd(CTIS_OFS_STOP, d);
    host.wr(CTIS_OFS_AUX_CTRL, 8'h40);
    host.rd(CTIS_OFS_START, d);
    measure_period(p);
    check8(p[7:0], 8'h08, "timer on pin 2 edges");
    @(posedge mclk_in);
    ext_run <= 1'b0;
    host.wr(CTIS_OFS_AUX_CTRL, 8'h70);
    host.rd(CTIS_OFS_START, d);
    measure_period(p);
    check8(p[7:0], 8'h40, "timer on crystal over 16");
  endtask : test_clock_sources

  // ****************************************************************
  // Main sequence and watchdog
  // ****************************************************************
  initial begin
    repeat (3) @(posedge mclk_in);
    rst_n_in <= 1'b1;
    test_reset();
    test_vector();
    test_input_change();
    test_sources();
    test_timer();
    test_counter();
    test_clock_sources();
    stop_test();
  end
  // Whole run needs well under a few thousand cycles
  initial begin
    repeat (20000) @(posedge mclk_in);
    mismatches++;
    stop_test();
  end
endmodule : ctis_top_test
